// file: design/csmp_pkg.sv
// package for the codec serial control port: pin indices, command layouts, reset values
// assumes a single 40 MHz ref_clk domain; all serial pins arrive asynchronously
//
// Functional notes
// - Sample clock level at every select activation
// - Clock high: LSB first, primary pin bidirectional
// - Clock low: MSB first, primary out, secondary in
// - Device ignores incoming bits during reads; code still copies them into wdat, without a write strobe
// - Access is command byte then data byte
// - First eight clocks carry the command byte
// - Command byte gives direction and register address
// - Clocks nine to sixteen carry the data
// - Primary pin released while select is high
// - Bit order follows mode, no configuration
// - Command layout differs per mode
// - Sample on rising edge, drive on falling
// - Bytes after the command are data
package csmp_pkg;

  // synchroniser lanes
  localparam int unsigned SYNC_W     = 4;
  localparam int unsigned IDX_SCLK   = 0;
  localparam int unsigned IDX_CS_N   = 1;
  localparam int unsigned IDX_PDATA  = 2;
  localparam int unsigned IDX_SDATA  = 3;

  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned ADDR_W     = 4;

  // command layout, clock-idle-high (lsb first) mode
  localparam int unsigned LSB_RW_POS   = 7;
  localparam int unsigned LSB_ADDR_LO  = 0;
  // command layout, clock-idle-low (msb first) mode
  localparam int unsigned MSB_RW_POS   = 0;
  localparam int unsigned MSB_ADDR_LO  = 4;

  // reset values, and the index of a byte's last bit
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [2:0]  RST_CNT    = 3'h0;
  localparam logic [3:0]  RST_ADDR   = 4'h0;
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  // transfer state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } csmp_state_t;

endpackage

// file: design/csmp_port.sv
// serial control port: two-byte command/data transfers to internal registers
// assumes the register file answers a read strobe with data on the next ref_clk
`timescale 1ns/1ps
`default_nettype none

module csmp_port #(
  parameter int unsigned AW = csmp_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // serial pins
  input  wire logic          sclk_pin,
  input  wire logic          cs_n_pin,
  input  wire logic          primary_serial_data_pin_i,
  output logic               primary_serial_data_pin_o,
  output logic               primary_serial_data_pin_oe,
  input  wire logic          secondary_serial_receive_pin,
  // register file side
  output logic [AW-1:0]      reg_addr,
  output logic [7:0]         reg_wr_data,
  output logic               reg_wr_stb,
  output logic               reg_rd_stb,
  input  wire logic [7:0]    reg_rd_data,
  // status
  output logic               lsb_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  csmp_sync_if #(.W(csmp_pkg::SYNC_W)) pins ();

  csmp_sync #(.W(csmp_pkg::SYNC_W)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({secondary_serial_receive_pin, primary_serial_data_pin_i,
                cs_n_pin, sclk_pin}),
    .sync     (pins.src)
  );

  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_lvl_n;
  logic cs_act;
  logic cs_rel;
  assign sclk_lvl  = pins.lvl[csmp_pkg::IDX_SCLK];
  assign sclk_rise = pins.rise[csmp_pkg::IDX_SCLK];
  assign sclk_fall = pins.fall[csmp_pkg::IDX_SCLK];
  assign cs_lvl_n  = pins.lvl[csmp_pkg::IDX_CS_N];
  assign cs_act    = pins.fall[csmp_pkg::IDX_CS_N];
  assign cs_rel    = pins.rise[csmp_pkg::IDX_CS_N];

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    csmp_pkg::csmp_state_t st;
    logic                  lsb;
    logic [2:0]            cnt;
    logic [7:0]            rx;
    logic [7:0]            tx;
    logic                  rd;
    logic                  load;
    logic [AW-1:0]         addr;
    logic [7:0]            wdat;
    logic                  wstb;
    logic                  rstb;
    logic                  dout;
    logic                  oe;
  } csmp_port_st_t;

  csmp_port_st_t s_q;
  csmp_port_st_t s_d;

  logic       rx_bit;
  logic [7:0] rx_next;

  // the receive pin depends on the mode caught at activation
  always_comb begin
    rx_bit = s_q.lsb ? pins.lvl[csmp_pkg::IDX_PDATA]
                     : pins.lvl[csmp_pkg::IDX_SDATA];
    rx_next = s_q.lsb ? {rx_bit, s_q.rx[7:1]}
                      : {s_q.rx[6:0], rx_bit};
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencing

  // strobes last one cycle; a released select always wins over a byte end
  always_comb begin
    s_d      = s_q;
    s_d.wstb = 1'b0;
    s_d.rstb = 1'b0;
    s_d.load = s_q.rstb;
    // read data arrives the cycle after the strobe
    if (s_q.load) begin
      s_d.tx = reg_rd_data;
    end
    unique case (s_q.st)
      csmp_pkg::ST_IDLE: begin
        s_d.oe = 1'b0;
      end
      csmp_pkg::ST_CMD: begin
        // command bits sampled on rising edges
        if (sclk_rise) begin
          s_d.rx  = rx_next;
          s_d.cnt = s_q.cnt + 3'h1;
          if (s_q.cnt == csmp_pkg::LAST_BIT) begin
            s_d.st = csmp_pkg::ST_DATA;
            // each mode keeps its own command layout
            if (s_q.lsb) begin
              s_d.rd   = rx_next[csmp_pkg::LSB_RW_POS];
              s_d.addr = rx_next[csmp_pkg::LSB_ADDR_LO +: AW];
            end else begin
              s_d.rd   = rx_next[csmp_pkg::MSB_RW_POS];
              s_d.addr = rx_next[csmp_pkg::MSB_ADDR_LO +: AW];
            end
            s_d.rstb = s_d.rd;
          end
        end
      end
      csmp_pkg::ST_DATA: begin
        // read data goes out on falling edges only
        if (sclk_fall && s_q.rd) begin
          s_d.oe   = 1'b1;
          s_d.dout = s_q.lsb ? s_q.tx[0] : s_q.tx[7];
          s_d.tx   = s_q.lsb ? {1'b0, s_q.tx[7:1]} : {s_q.tx[6:0], 1'b0};
        end
        if (sclk_rise) begin
          // incoming bits during a read are counted and copied to wdat but never strobed
          s_d.rx  = rx_next;
          s_d.cnt = s_q.cnt + 3'h1;
          if (s_q.cnt == csmp_pkg::LAST_BIT) begin
            // later bytes stay data, writes repeat to the same address
            s_d.wstb = ~s_q.rd;
            s_d.wdat = rx_next;
            s_d.rstb = s_q.rd;
          end
        end
      end
      default: begin
        s_d.st = csmp_pkg::ST_IDLE;
      end
    endcase
    // activation restarts the command byte and catches the mode
    if (cs_act) begin
      s_d.st  = csmp_pkg::ST_CMD;
      s_d.lsb = sclk_lvl;
      s_d.cnt = csmp_pkg::RST_CNT;
      s_d.oe  = 1'b0;
    end
    // release drops any partial byte and releases the pin
    if (cs_rel || cs_lvl_n) begin
      s_d.st   = csmp_pkg::ST_IDLE;
      s_d.oe   = 1'b0;
      s_d.wstb = 1'b0;
      s_d.rstb = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q      <= '0;
      s_q.st   <= csmp_pkg::ST_IDLE;
      s_q.rx   <= csmp_pkg::RST_BYTE;
      s_q.tx   <= csmp_pkg::RST_BYTE;
      s_q.wdat <= csmp_pkg::RST_BYTE;
      s_q.addr <= csmp_pkg::RST_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign primary_serial_data_pin_o  = s_q.dout;
  assign primary_serial_data_pin_oe = s_q.oe;
  assign reg_addr                   = s_q.addr;
  assign reg_wr_data                = s_q.wdat;
  assign reg_wr_stb                 = s_q.wstb;
  assign reg_rd_stb                 = s_q.rstb;
  assign lsb_mode                   = s_q.lsb;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_mode_capture;
    @(posedge ref_clk) disable iff (!rst_n)
    (cs_act && !cs_lvl_n) |=> (s_q.lsb == $past(sclk_lvl));
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("mode not taken from clock level at select");

  property p_release_hiz;
    @(posedge ref_clk) disable iff (!rst_n)
    cs_lvl_n |=> !s_q.oe;
  endproperty
  a_release_hiz: assert property (p_release_hiz)
    else $error("primary pin driven while select high");

  property p_cmd_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (cs_act && !cs_lvl_n) |=> (s_q.st == csmp_pkg::ST_CMD) && (s_q.cnt == 3'h0);
  endproperty
  a_cmd_start: assert property (p_cmd_start)
    else $error("command byte not restarted at select");

  property p_no_write_on_read;
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.wstb |-> !s_q.rd && $past(s_q.st == csmp_pkg::ST_DATA);
  endproperty
  a_no_write_on_read: assert property (p_no_write_on_read)
    else $error("write strobe during read or outside data byte");

  property p_drive_on_fall;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(s_q.oe) |-> $past(sclk_fall) && s_q.rd;
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("output enabled away from a falling clock edge");

  property p_abandon;
    @(posedge ref_clk) disable iff (!rst_n)
    cs_rel |=> (s_q.st == csmp_pkg::ST_IDLE) && !s_q.wstb ##1 !s_q.wstb;
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("write issued after select release");

  property p_data_stays;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_q.st == csmp_pkg::ST_DATA) && !cs_act |=> (s_q.st != csmp_pkg::ST_CMD);
  endproperty
  a_data_stays: assert property (p_data_stays)
    else $error("later byte taken as command");

  property p_read_load;
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.rstb |=> s_q.load ##1 (s_q.tx == $past(reg_rd_data));
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read data not loaded after read strobe");

  c_write: cover property (@(posedge ref_clk) disable iff (!rst_n) s_q.wstb && !s_q.lsb);
  c_write_lsb: cover property (@(posedge ref_clk) disable iff (!rst_n) s_q.wstb && s_q.lsb);
  c_read: cover property (@(posedge ref_clk) disable iff (!rst_n) s_q.rstb ##[1:200] s_q.oe);

endmodule

`default_nettype wire

// file: design/csmp_sync.sv
// two-flop synchroniser with edge detection for W asynchronous pins
// assumes ref_clk is well above the pin toggle rate (5x or more)
`timescale 1ns/1ps
`default_nettype none

module csmp_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // raw pins
  input  wire logic [W-1:0] async_in,
  // synchronised side
  csmp_sync_if.src          sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } csmp_sync_st_t;

  csmp_sync_st_t s_q;
  csmp_sync_st_t s_d;

  // first stage only feeds the second; edges look at stages two and three
  always_comb begin
    s_d    = s_q;
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  // idle pins reset high so no false edge appears at release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync.lvl  = s_q.s2;
  assign sync.rise = s_q.s2 & ~s_q.s3;
  assign sync.fall = ~s_q.s2 & s_q.s3;

endmodule

`default_nettype wire

// file: design/csmp_sync_if.sv
// carrier for synchronised pin levels and their edge pulses
// assumes the producer and consumer share ref_clk
`timescale 1ns/1ps
`default_nettype none

interface csmp_sync_if #(parameter int unsigned W = 4);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

`default_nettype wire

// file: testbench/codec_serial_microport_test.sv
// self-checking bench for the serial control port with a small register file model
// assumes csmp_ctrl_model stands in for the controller on the link
`timescale 1ns/1ps
`default_nettype none

module codec_serial_microport_test;
  localparam int LIMIT = 20000;

  logic       ref_clk, rst_n, sclk_pin, cs_n_pin, m_d, m_oe, s_d;
  logic       pd_o, pd_oe, last_q, pd_wire, reg_wr_stb, reg_rd_stb, lsb_mode;
  logic [3:0] reg_addr, wr_addr;
  logic [7:0] reg_wr_data, reg_rd_data, wr_data;
  logic [7:0] regs [16];
  int         n_fail, checked, n_wr, cyc;

  // nobody driving: wire shows the inverse of its last level, never a stale value
  assign pd_wire = pd_oe ? pd_o : (m_oe ? m_d : ~last_q);

  csmp_port u_csmp_port (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .primary_serial_data_pin_i(pd_wire), .primary_serial_data_pin_o(pd_o),
    .primary_serial_data_pin_oe(pd_oe), .secondary_serial_receive_pin(s_d),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .lsb_mode(lsb_mode));

  csmp_ctrl_model u_csmp_ctrl_model (
    .ref_clk(ref_clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .m_d(m_d),
    .m_oe(m_oe), .s_d(s_d), .pd_wire(pd_wire));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // register file: read data valid the cycle after the strobe; write log; hang limit
  always @(posedge ref_clk) begin
    last_q <= pd_wire;
    cyc = cyc + 1;
    if (reg_wr_stb === 1'b1) begin
      n_wr <= n_wr + 1;
      wr_addr <= reg_addr;
      wr_data <= reg_wr_data;
    end
    if (reg_rd_stb === 1'b1) reg_rd_data <= regs[reg_addr];
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked = checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // command layout per mode: read flag and address field
  function automatic logic [7:0] cmd_of(input logic lsb, input logic rd, input logic [3:0] a);
    return lsb ? {rd, 3'h0, a} : {a, 3'h0, rd};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // write access; short counts abort, long counts write the inverted data byte again
  task automatic t_write(input logic lsb, input logic [3:0] a, input logic [7:0] d,
                         input int nbits);
    int         n0;
    logic [7:0] rx;
    n0 = n_wr;
    u_csmp_ctrl_model.xfer(lsb, cmd_of(lsb, 1'b0, a), d, nbits, rx);
    repeat (6) @(posedge ref_clk);
    check({7'h00, lsb_mode}, {7'h00, lsb}, "mode");
    check({7'h00, pd_oe}, 8'h00, "primary released");
    if (nbits < 16) check(8'(n_wr - n0), 8'h00, "aborted write");
    else begin
      check(8'(n_wr - n0), 8'((nbits - 8) / 8), "write count");
      check({4'h0, wr_addr}, {4'h0, a}, "write addr");
      check(wr_data, (nbits > 16) ? ~d : d, "write data");
    end
  endtask

  // read access while the controller shifts junk toward the device
  task automatic t_read(input logic lsb, input logic [3:0] a, input logic [7:0] d);
    int         n0;
    logic [7:0] rx;
    regs[a] = d;
    n0 = n_wr;
    u_csmp_ctrl_model.xfer(lsb, cmd_of(lsb, 1'b1, a), ~d, 16, rx);
    repeat (6) @(posedge ref_clk);
    check(rx, d, "read data");
    check(8'(n_wr - n0), 8'h00, "read wrote");
    check({7'h00, pd_oe}, 8'h00, "primary released");
  endtask

  // main sequence, every access in msb mode first, then all of them in lsb mode
  initial begin
    rst_n = 1'b0;
    reg_rd_data = 8'h00;
    last_q = 1'b0;
    n_fail = 0;
    checked = 0;
    n_wr = 0;
    cyc = 0;
    for (int i = 0; i < 16; i++) regs[i] = 8'h00;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int m = 0; m < 2; m++) begin
      t_write(m[0], 4'h5, 8'hA3, 16);
      t_write(m[0], 4'hF, 8'h81, 16);
      t_read(m[0], 4'hA, 8'hC5);
      t_read(m[0], 4'h0, 8'h1E);
      t_write(m[0], 4'h3, 8'h5A, 12);
      t_write(m[0], 4'h6, 8'h96, 24);
    end
    end_of_test();
  end

endmodule

`default_nettype wire

// file: testbench/csmp_ctrl_model.sv
// controller model: drives select, serial clock and data, and clocks back read bits
// assumes the bench resolves the primary wire and feeds it back on pd_wire
`timescale 1ns/1ps
`default_nettype none

module csmp_ctrl_model (
  // clock
  input  wire logic ref_clk,
  // controller pins
  output logic      sclk_pin,
  output logic      cs_n_pin,
  output logic      m_d,
  output logic      m_oe,
  output logic      s_d,
  // resolved primary wire
  input  wire logic pd_wire
);
  // ref_clk cycles per sclk half period, 200 ns serial period
  localparam int HALF = 4;

  // idle pins at time zero
  initial begin
    sclk_pin = 1'b1;
    cs_n_pin = 1'b1;
    m_d = 1'b0;
    m_oe = 1'b0;
    s_d = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // one access: command byte, data byte, further bytes carry the inverted data
  task automatic xfer(input logic lsb, input logic [7:0] cmd, input logic [7:0] dat,
                      input int nbits, output logic [7:0] rx);
    logic [7:0] b;
    logic       rd;
    int         k;
    rx = 8'h00;
    rd = lsb ? cmd[7] : cmd[0];
    sclk_pin <= lsb;
    repeat (HALF) @(posedge ref_clk);
    cs_n_pin <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      b = (i < 8) ? cmd : (i < 16) ? dat : ~dat;
      k = lsb ? i % 8 : 7 - i % 8;
      sclk_pin <= 1'b0;
      m_d <= b[k];
      m_oe <= lsb && !(rd && i >= 8);
      s_d <= lsb ? ~b[k] : b[k];
      repeat (HALF) @(posedge ref_clk);
      sclk_pin <= 1'b1;
      // write-phase bits on the receive line are never kept
      if (rd && i >= 8 && i < 16) rx[k] = pd_wire;
      repeat (HALF) @(posedge ref_clk);
    end
    if (!lsb) sclk_pin <= 1'b0;
    m_oe <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    cs_n_pin <= 1'b1;
    repeat (HALF) @(posedge ref_clk);
  endtask

endmodule

`default_nettype wire
